// ==== rpc_core.sv ====
// Shared repeater core and per-port logic with address security
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
module rpc_core
  import rpc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // APB slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // Segment side, already Manchester-decoded NRZ per port
  input  wire logic [NPORT-1:0]   rx_act_i,
  input  wire logic [NPORT-1:0]   rx_data_i,
  input  wire logic [NPORT-1:0]   rx_col_i,
  input  wire logic               rx_crc_ok_i,
  input  wire logic [NPORT-1:0]   xcvr_ext_i,
  output logic      [NPORT-1:0]   tx_en_o,
  output logic      [NPORT-1:0]   tx_data_o,
  // Cascade expansion bus, recovered NRZ with clock enable
  output logic                    casc_data_o,
  output logic                    casc_clk_o,
  output logic                    casc_en_o,
  output logic                    casc_col_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0]                   rdata;
    logic                          ready;
    logic                          err;
    logic                          secure;
    logic                          learn;
    logic [NPORT-1:0][7:0]         pstat;
    logic [NPORT-1:0][7:0]         pcoll;
    logic [NPORT-1:0]              lidx;
    logic [NPORT-1:0][1:0][ADDR_W-1:0] paddr;
    logic [SHARED-1:0][ADDR_W-1:0] saddr;
    logic [SHARED-1:0][NPORT-1:0]  smask;
    logic [SHARED-1:0]             svalid;
    logic [5:0]                    sel;
    logic [ADDR_W-1:0]             wbuf;
    rpc_msm_t                      main_repeat_state_machine;
    rpc_psm_t [NPORT-1:0]          per_port_state_machine;
    logic [PW-1:0]                 src;
    logic [7:0]                    bdiv;
    logic [7:0]                    tmr;
    logic [2:0]                    twi;
    logic [7:0]                    pre_cnt;
    logic                          sfd_seen;
    logic                          prev_bit;
    logic [EB_W-1:0]               eb;
    logic [EB_AW:0]                eb_wp;
    logic [EB_AW:0]                eb_rp;
    logic [11:0]                   bitcnt;
    logic [ADDR_W-1:0]             da;
    logic [ADDR_W-1:0]             sa;
    logic [NPORT-1:0]              scr_port;
    logic                          scr_casc;
    logic                          cmp_done;
    logic [15:0]                   lfsr;
    logic [NPORT-1:0]              txe;
    logic [NPORT-1:0]              txd;
    logic                          cd;
    logic                          cc;
    logic                          ce;
    logic                          ccol;
  } rpc_state_t;

  rpc_state_t s_r, s_nxt;
  logic [NPORT-1:0] act_s1_r, act_s2_r, dat_s1_r, dat_s2_r, col_s1_r, col_s2_r;
  logic             crc_s1_r, crc_s2_r;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [PW-1:0] low_port(input logic [NPORT-1:0] v);
    logic [PW-1:0] r;
    r = '0;
    for (int i = NPORT - 1; i >= 0; i--) begin
      if (v[i]) r = PW'(i);
    end
    return r;
  endfunction : low_port

  // Whether address a is allowed on port p
  function automatic logic addr_ok(input rpc_state_t s, input logic [ADDR_W-1:0] a,
                                   input int p);
    logic r;
    r = (s.paddr[p][0] == a) || (s.paddr[p][1] == a);
    for (int k = 0; k < SHARED; k++) begin
      if (s.svalid[k] && s.smask[k][p] && s.saddr[k] == a) r = 1'b1;
    end
    return r;
  endfunction : addr_ok

  // ****************************************************************
  // Input synchronisers for segment pins
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    act_s1_r <= rx_act_i;
    act_s2_r <= act_s1_r;
    dat_s1_r <= rx_data_i;
    dat_s2_r <= dat_s1_r;
    col_s1_r <= rx_col_i;
    col_s2_r <= col_s1_r;
    crc_s1_r <= rx_crc_ok_i;
    crc_s2_r <= crc_s1_r;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic             bit_en, any_col, multi, eligible, rxbit, jam, wr;
    logic [NPORT-1:0] act_ok;
    int               idx, p;
    s_nxt    = s_r;
    idx      = 0;
    p        = 0;
    act_ok   = act_s2_r;
    bit_en   = 1'b0;
    any_col  = 1'b0;
    multi    = 1'b0;
    eligible = 1'b0;
    rxbit    = 1'b0;
    jam      = 1'b0;
    // Writes land only at the access edge that the master sees ready on
    wr       = psel_i && penable_i && pwrite_i && s_r.ready;
    // Free-running scramble source, x^16+x^14+x^13+x^11+1
    s_nxt.lfsr = {s_r.lfsr[14:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};

    // APB: zero wait state, answer in the access phase
    s_nxt.ready = psel_i && !penable_i;
    s_nxt.err   = 1'b0;
    if (psel_i && (!penable_i || wr)) begin
      s_nxt.rdata = '0;
      if (paddr_i == A_CTRL) begin
        s_nxt.rdata = {30'h0, s_r.learn, s_r.secure};
        if (wr) begin
          s_nxt.secure = pwdata_i[0];
          s_nxt.learn  = pwdata_i[1];
        end
      end else if (paddr_i == A_STAT) begin
        s_nxt.rdata = {23'h0, s_r.scr_casc, 1'b0, s_r.main_repeat_state_machine, s_r.src};
      end else if (paddr_i >= A_PORT0 && paddr_i < A_PORT0 + 12'(4 * NPORT)) begin
        idx = int'(paddr_i - A_PORT0) >> 2;
        s_nxt.rdata = {24'h0, s_r.pstat[idx]};
        if (wr) begin
          s_nxt.pstat[idx][PS_DIS] = pwdata_i[PS_DIS];
          s_nxt.pstat[idx][PS_SEC] = pwdata_i[PS_SEC];
          if (!pwdata_i[PS_PART]) s_nxt.pstat[idx][PS_PART] = 1'b0; // Write 0 reconnects
        end
      end else if (paddr_i == A_SVALID) begin
        s_nxt.rdata = s_r.svalid;
        if (wr) s_nxt.svalid = pwdata_i;
      end else if (paddr_i == A_SEL) begin
        s_nxt.rdata = {26'h0, s_r.sel};
        if (wr) s_nxt.sel = pwdata_i[5:0];
      end else if (paddr_i == A_ALO) begin
        s_nxt.rdata = s_r.wbuf[31:0];
        if (wr) s_nxt.wbuf[31:0] = pwdata_i;
      end else if (paddr_i == A_AHI) begin
        s_nxt.rdata = {16'h0, s_r.wbuf[47:32]};
        if (wr) begin
          s_nxt.wbuf[47:32] = pwdata_i[15:0];
          // Bit 31 selects shared entry, else sel[4:1] port and sel[0] slot
          if (pwdata_i[31]) s_nxt.saddr[s_r.sel[4:0]] = {pwdata_i[15:0], s_r.wbuf[31:0]};
          else if (int'(s_r.sel[4:1]) < NPORT)
            s_nxt.paddr[s_r.sel[4:1]][s_r.sel[0]] = {pwdata_i[15:0], s_r.wbuf[31:0]};
        end
      end else if (paddr_i == A_SMASK) begin
        s_nxt.rdata = {19'h0, s_r.smask[s_r.sel[4:0]]};
        if (wr) s_nxt.smask[s_r.sel[4:0]] = pwdata_i[NPORT-1:0];
      end else begin
        s_nxt.err = !penable_i;
      end
    end

    // Bit-time enable
    bit_en = (s_r.bdiv == 8'(BIT_CYC - 1));
    s_nxt.bdiv = bit_en ? 8'h00 : s_r.bdiv + 8'h01;

    // Disabled or partitioned ports do not count as receivers
    for (int i = 0; i < NPORT; i++) begin
      act_ok[i] = act_s2_r[i] && !s_r.pstat[i][PS_DIS] && !s_r.pstat[i][PS_PART];
      s_nxt.pstat[i][PS_XT] = (i != 0) && xcvr_ext_i[i];
    end
    any_col = |(col_s2_r & act_ok);
    multi   = (act_ok & (act_ok - NPORT'(1))) != '0;
    jam     = any_col || multi;
    rxbit   = dat_s2_r[s_r.src];

    // Main repeat machine
    s_nxt.ce = 1'b0;
    s_nxt.cc = 1'b0;
    unique case (s_r.main_repeat_state_machine)
      MS_IDLE: begin
        if (act_ok != '0) begin
          s_nxt.src      = low_port(act_ok);
          s_nxt.main_repeat_state_machine      = MS_PRE;
          s_nxt.pre_cnt  = '0;
          s_nxt.sfd_seen = 1'b0;
          s_nxt.eb_wp    = '0;
          s_nxt.eb_rp    = '0;
          s_nxt.bitcnt   = '0;
          s_nxt.scr_port = '0;
          s_nxt.scr_casc = 1'b0;
          s_nxt.cmp_done = 1'b0;
          // A one left over from the last frame would fake a delimiter
          s_nxt.prev_bit = 1'b0;
        end
      end
      MS_PRE, MS_DATA: begin
        if (jam) begin
          s_nxt.main_repeat_state_machine = MS_JAM;
        end else if (!act_ok[s_r.src] && s_r.eb_rp == s_r.eb_wp && s_r.sfd_seen) begin
          s_nxt.main_repeat_state_machine = MS_WAIT;
          s_nxt.twi = 3'd0;
          s_nxt.tmr = TW_BITS[0];
        end else if (bit_en) begin
          s_nxt.cc = 1'b1;
          s_nxt.ce = 1'b1;
          s_nxt.cd = rxbit;
          s_nxt.prev_bit = rxbit;
          if (s_r.pre_cnt != 8'(PRE_BITS)) s_nxt.pre_cnt = s_r.pre_cnt + 8'h01;
          // Decoded stream seen through the cascade path
          if (!s_r.sfd_seen) begin
            if (s_r.prev_bit && rxbit) s_nxt.sfd_seen = 1'b1;
          end else if (act_ok[s_r.src]
                       && (s_r.eb_wp - s_r.eb_rp) != (EB_AW+1)'(EB_W)) begin
            s_nxt.eb[s_r.eb_wp[EB_AW-1:0]] = s_s_bit(rxbit);
            s_nxt.eb_wp = s_r.eb_wp + 1'b1;
            s_nxt.bitcnt = s_r.bitcnt + 12'h001;
            if (int'(s_r.bitcnt) < DA_END) s_nxt.da = {rxbit, s_r.da[ADDR_W-1:1]};
            else if (int'(s_r.bitcnt) < SA_END) s_nxt.sa = {rxbit, s_r.sa[ADDR_W-1:1]};
          end
          // Reads start only once a full preamble went out
          if (s_r.main_repeat_state_machine == MS_DATA && s_r.eb_rp != s_r.eb_wp) s_nxt.eb_rp = s_r.eb_rp + 1'b1;
          if (s_r.main_repeat_state_machine == MS_PRE && s_r.pre_cnt == 8'(PRE_BITS) && s_r.sfd_seen) s_nxt.main_repeat_state_machine = MS_DATA;
        end
        // Compare well before data field bits leave the buffer
        if (!s_r.cmp_done && int'(s_r.bitcnt) >= SA_END) begin
          s_nxt.cmp_done = 1'b1;
          if (s_r.secure) begin
            if (!addr_ok(s_r, s_r.sa, int'(s_r.src))) begin
              s_nxt.scr_port = '1;
              s_nxt.scr_casc = 1'b1;
            end else begin
              for (int i = 0; i < NPORT; i++) begin
                if (s_r.pstat[i][PS_SEC] && !addr_ok(s_r, s_r.da, i)) s_nxt.scr_port[i] = 1'b1;
              end
              s_nxt.scr_casc = 1'b0;
            end
          end
        end
      end
      MS_JAM: begin
        if (bit_en) begin
          s_nxt.cc = 1'b1;
          s_nxt.ce = 1'b1;
        end
        if (act_ok == '0) begin
          s_nxt.main_repeat_state_machine = MS_WAIT;
          s_nxt.twi = 3'd1;
          s_nxt.tmr = TW_BITS[1];
        end
      end
      MS_WAIT: begin
        if (bit_en) begin
          if (s_r.tmr != 8'h00) begin
            s_nxt.tmr = s_r.tmr - 8'h01;
          end else if (int'(s_r.twi) < TW_N - 1 && s_r.twi != 3'd1 && s_r.twi != 3'd0) begin
            s_nxt.twi = s_r.twi + 3'd1;
            s_nxt.tmr = TW_BITS[s_r.twi + 3'd1];
          end else begin
            s_nxt.main_repeat_state_machine = MS_IDLE;
          end
        end
      end
      default: s_nxt.main_repeat_state_machine = MS_IDLE;
    endcase

    // Per-port machines and transmit data
    for (int i = 0; i < NPORT; i++) begin
      eligible = !s_r.pstat[i][PS_DIS];
      unique case (s_r.per_port_state_machine[i])
        PS_IDLE: if (act_ok[i] && s_r.main_repeat_state_machine == MS_IDLE) s_nxt.per_port_state_machine[i] = PS_RECV;
                 else if (s_r.main_repeat_state_machine == MS_PRE) s_nxt.per_port_state_machine[i] = PS_SEND;
        PS_RECV: if (jam) s_nxt.per_port_state_machine[i] = PS_COLL;
                 else if (s_r.main_repeat_state_machine == MS_WAIT || s_r.main_repeat_state_machine == MS_IDLE) s_nxt.per_port_state_machine[i] = PS_IDLE;
        PS_SEND: if (jam) s_nxt.per_port_state_machine[i] = PS_COLL;
                 else if (s_r.main_repeat_state_machine == MS_WAIT || s_r.main_repeat_state_machine == MS_IDLE) s_nxt.per_port_state_machine[i] = PS_IDLE;
        PS_COLL: if (s_r.main_repeat_state_machine == MS_WAIT || s_r.main_repeat_state_machine == MS_IDLE) s_nxt.per_port_state_machine[i] = PS_IDLE;
      endcase
      s_nxt.pstat[i][PS_RX]  = (s_r.per_port_state_machine[i] == PS_RECV);
      s_nxt.pstat[i][PS_TX]  = (s_r.per_port_state_machine[i] == PS_SEND);
      s_nxt.pstat[i][PS_COL] = (s_r.per_port_state_machine[i] == PS_COLL);
      // Partition after too many consecutive collisions, clear on clean receive
      if (s_r.per_port_state_machine[i] != PS_COLL && s_nxt.per_port_state_machine[i] == PS_COLL && act_s2_r[i]) begin
        if (s_r.pcoll[i] == PART_LIMIT) s_nxt.pstat[i][PS_PART] = 1'b1;
        else s_nxt.pcoll[i] = s_r.pcoll[i] + 8'h01;
      end else if (s_r.per_port_state_machine[i] == PS_RECV && s_nxt.per_port_state_machine[i] == PS_IDLE) begin
        s_nxt.pcoll[i] = '0;
      end
      // Learn mode: capture source on good CRC, alternating slots
      if (s_r.learn && s_r.per_port_state_machine[i] == PS_RECV && s_nxt.per_port_state_machine[i] == PS_IDLE
          && crc_s2_r && int'(s_r.bitcnt) >= SA_END) begin
        s_nxt.paddr[i][s_r.lidx[i]] = s_r.sa;
        s_nxt.lidx[i] = !s_r.lidx[i];
      end
      s_nxt.txe[i] = eligible && (s_r.per_port_state_machine[i] == PS_SEND || s_r.per_port_state_machine[i] == PS_COLL)
                     && !(s_r.main_repeat_state_machine != MS_JAM && i == int'(s_r.src));
      if (s_r.main_repeat_state_machine == MS_JAM || s_r.main_repeat_state_machine == MS_PRE) begin
        s_nxt.txd[i] = s_r.pre_cnt[0] ^ s_r.bdiv[0] ? 1'b1 : 1'b0;
        if (bit_en) s_nxt.txd[i] = !s_r.txd[i]; // 1010 for jam and preamble
      end else if (s_r.main_repeat_state_machine == MS_DATA && bit_en) begin
        s_nxt.txd[i] = s_r.scr_port[i] ? s_r.lfsr[0] : s_r.eb[s_r.eb_rp[EB_AW-1:0]];
      end
    end
    s_nxt.ccol = jam;
    if (s_r.scr_casc && s_r.main_repeat_state_machine == MS_DATA) s_nxt.cd = s_r.lfsr[1];
  end

  // Identity helper keeps the buffer write path explicit
  function automatic logic s_s_bit(input logic b);
    return b;
  endfunction : s_s_bit

  // ****************************************************************
  // Register stage
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r      <= '0;
      s_r.main_repeat_state_machine  <= MS_IDLE;
      s_r.lfsr <= LFSR_SEED;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o    = s_r.rdata;
  assign pready_o    = s_r.ready;
  assign pslverr_o   = s_r.err;
  assign tx_en_o     = s_r.txe;
  assign tx_data_o   = s_r.txd;
  assign casc_data_o = s_r.cd;
  assign casc_clk_o  = s_r.cc;
  assign casc_en_o   = s_r.ce;
  assign casc_col_o  = s_r.ccol;
endmodule : rpc_core

// ==== rpc_pkg.sv ====
// Package with constants and types for the repeater core with security
package rpc_pkg;
  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NPORT   = 13;
  localparam int PW      = 4;     // Port index width
  localparam int SHARED  = 32;
  localparam int ADDR_W  = 48;
  localparam int EB_W    = 32;
  localparam int EB_AW   = 5;
  // ****************************************************************
  // Timing, bit times at 10 Mb/s are enable pulses from clk_i
  // ****************************************************************
  localparam int CLK_MHZ     = 100;
  localparam int BIT_NS      = 100;
  localparam int BIT_CYC     = BIT_NS * CLK_MHZ / 1000;
  localparam int PRE_BITS    = 62;          // Valid preamble length before SFD
  localparam int TW_N        = 6;
  localparam logic [7:0] TW_BITS [TW_N] = '{8'h60, 8'h60, 8'h20, 8'h60, 8'h60, 8'h60};
  localparam logic [7:0] PART_LIMIT     = 8'h1f; // Consecutive collisions counted; the next one partitions
  localparam int DA_END   = 48;                  // Bit count where DA is complete
  localparam int SA_END   = 96;
  localparam int CMP_END  = 112;                 // Data field starts after type
  // ****************************************************************
  // APB register map, byte addresses
  // ****************************************************************
  localparam logic [11:0] A_CTRL    = 12'h000; // [0] secure, [1] learn
  localparam logic [11:0] A_STAT    = 12'h004; // [3:0] rx port, [6:4] state, [8] scramble
  localparam logic [11:0] A_PORT0   = 12'h040; // Port status, one word per port
  localparam logic [11:0] A_SVALID  = 12'h080; // Shared entry valid bits
  localparam logic [11:0] A_SEL     = 12'h084; // Entry select for address writes
  localparam logic [11:0] A_ALO     = 12'h088; // Address low 32 bits
  localparam logic [11:0] A_AHI     = 12'h08c; // Address high 16 bits, [31] write shared
  localparam logic [11:0] A_SMASK   = 12'h090; // Port mask of selected shared entry
  // Port status bits
  localparam int PS_DIS  = 0;
  localparam int PS_SEC  = 1;
  localparam int PS_PART = 2;
  localparam int PS_RX   = 3;
  localparam int PS_TX   = 4;
  localparam int PS_COL  = 5;
  localparam int PS_XT   = 6;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  typedef enum logic [2:0] {MS_IDLE, MS_PRE, MS_DATA, MS_JAM, MS_WAIT} rpc_msm_t;
  typedef enum logic [1:0] {PS_IDLE, PS_RECV, PS_SEND, PS_COLL} rpc_psm_t;
endpackage : rpc_pkg

// ==== rpc_core_props.sv ====
// Port-level assertion checker for the repeater core
`timescale 1ns/100ps
module rpc_core_props
  import rpc_pkg::*;
(
  // Clock, reset and register bus
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [11:0]      paddr_i,
  input wire logic [31:0]      pwdata_i,
  input wire logic [31:0]      prdata_o,
  input wire logic             pready_o,
  input wire logic             pslverr_o,
  // Segments and cascade
  input wire logic [NPORT-1:0] rx_act_i,
  input wire logic [NPORT-1:0] rx_data_i,
  input wire logic [NPORT-1:0] rx_col_i,
  input wire logic             rx_crc_ok_i,
  input wire logic [NPORT-1:0] xcvr_ext_i,
  input wire logic [NPORT-1:0] tx_en_o,
  input wire logic [NPORT-1:0] tx_data_o,
  input wire logic             casc_data_o,
  input wire logic             casc_clk_o,
  input wire logic             casc_en_o,
  input wire logic             casc_col_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ****************************************************************
  // Sequences
  // ****************************************************************
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  // Port zero alone active long enough to clear the synchroniser
  sequence s_solo;
    (rx_act_i == 13'h0001 && rx_col_i == '0) [*4];
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  a_ready_next: assert property (s_setup |=> pready_o)
    else $error("ready missing after setup");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  a_err_unmapped: assert property (s_setup ##0 paddr_i == 12'h0fc |=> pslverr_o && pready_o)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (s_setup ##0 paddr_i == A_CTRL |=> !pslverr_o)
    else $error("mapped access refused");
  a_src_quiet: assert property (s_solo |-> !tx_en_o[0])
    else $error("receiving port transmits");
  a_pre_start: assert property ($rose(rx_act_i[0]) && tx_en_o == '0 |-> ##[1:8] tx_en_o[1])
    else $error("preamble not started");
  a_col_jam: assert property (rx_act_i[0] && rx_col_i[0] |-> ##[1:8] casc_col_o)
    else $error("collision not signalled");
  a_bit_gap: assert property (casc_clk_o |=> !casc_clk_o [*8])
    else $error("cascade bit clock too fast");
endmodule : rpc_core_props

bind rpc_core rpc_core_props u_props (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_act_i, .rx_data_i, .rx_col_i, .rx_crc_ok_i,
  .xcvr_ext_i, .tx_en_o, .tx_data_o, .casc_data_o, .casc_clk_o, .casc_en_o, .casc_col_o);

// ==== rpc_seg_model.sv ====
// Segment model: one station sending frames into port zero
`timescale 1ns/100ps
module rpc_seg_model
  import rpc_pkg::*;
(
  input  wire logic             clk_i,
  output logic      [NPORT-1:0] rx_act_o,
  output logic      [NPORT-1:0] rx_data_o,
  output logic      [NPORT-1:0] rx_col_o,
  output logic                  crc_ok_o
);
  localparam logic [47:0] DA = 48'h1122_3344_5566;
  localparam logic [47:0] SA = 48'h0a0b_0c0d_0e0f;
  localparam logic [63:0] PL = 64'h0123_4567_89ab_cdef;
  logic busy;
  initial begin
    rx_act_o = '0;
    rx_data_o = '0;
    rx_col_o = '0;
    crc_ok_o = 1'b0;
    busy = 1'b0;
  end
  // Idle line wanders so a stale level is never taken for data
  always @(posedge clk_i) begin
    if (!busy) rx_data_o <= ~rx_data_o;
  end
  task automatic send_bit(input logic b);
    rx_data_o <= {NPORT{b}};
    repeat (BIT_CYC) @(posedge clk_i);
  endtask : send_bit
  task automatic send_frame(input logic col);
    logic [159:0] hdr;
    hdr = {PL, SA, DA};
    busy = 1'b1;
    rx_act_o <= 13'h0001;
    for (int i = 0; i < PRE_BITS; i++) send_bit(~i[0]);
    send_bit(1'b1);
    send_bit(1'b1);
    for (int i = 0; i < 160; i++) begin
      if (col && i == 100) rx_col_o <= 13'h0001;
      send_bit(hdr[i]);
    end
    rx_act_o <= '0;
    rx_col_o <= '0;
    crc_ok_o <= 1'b1;
    @(posedge clk_i);
    crc_ok_o <= 1'b0;
    busy = 1'b0;
  endtask : send_frame
endmodule : rpc_seg_model

// ==== rpc_core_tb.sv ====
// Self-checking testbench for the repeater core
`timescale 1ns/100ps
module rpc_core_tb;
  import rpc_pkg::*;
  localparam logic [63:0] PL = 64'h0123_4567_89ab_cdef;
  logic             clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, err;
  logic             casc_data, casc_clk, casc_en, casc_col, crc_ok;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [NPORT-1:0] rx_act, rx_data, rx_col, tx_en, tx_data;
  logic [255:0]     cap;
  int               bad_count, check_count, cyc;
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n_i} = '0;
    cap = '0;
    cyc = 0;
  end
  rpc_core DUT (.clk_i, .rst_n_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_act_i(rx_act),
    .rx_data_i(rx_data), .rx_col_i(rx_col), .rx_crc_ok_i(crc_ok), .xcvr_ext_i('0), .tx_en_o(tx_en),
    .tx_data_o(tx_data), .casc_data_o(casc_data), .casc_clk_o(casc_clk), .casc_en_o(casc_en),
    .casc_col_o(casc_col));
  rpc_seg_model u_seg (.clk_i, .rx_act_o(rx_act), .rx_data_o(rx_data), .rx_col_o(rx_col), .crc_ok_o(crc_ok));
  // ****************************************************************
  // Cascade capture and watchdog
  // ****************************************************************
  always @(posedge clk_i) begin
    if (casc_clk) cap <= {casc_data, cap[255:1]};
    if (casc_clk || casc_en) chk(casc_en === casc_clk, "cascade enable with clock");
  end
  // Four frames with their waits need about 14000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  function automatic logic found(input logic [255:0] c);
    found = 1'b0;
    for (int i = 0; i <= 192; i++) if (c[i+:64] === PL) found = 1'b1;
  endfunction : found
  // Entered just after a rising edge; pready is taken at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic frame(input logic col, input logic exp);
    cap <= '0;
    fork
      u_seg.send_frame(col);
      begin
        repeat (100) @(posedge clk_i);
        @(negedge clk_i);
        chk(tx_en[1] === 1'b1 && tx_en[0] === 1'b0 && tx_en[5] === 1'b0, "preamble fan-out");
        if (col) begin
          repeat (1800) @(posedge clk_i);
          chk(casc_col === 1'b1, "jam on collision");
        end
      end
    join
    repeat (120 * BIT_CYC) @(posedge clk_i);
    chk(tx_en === '0, "transmit released after wait");
    if (!col) chk(found(cap) === exp, "cascade data field");
  endtask : frame
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(tx_en === '0 && pready === 1'b0 && casc_col === 1'b0, "outputs after reset");
    apb(1'b1, A_PORT0 + 12'h014, 32'h1);
    apb(1'b0, A_PORT0 + 12'h014, 32'h0);
    chk(rd[PS_DIS] === 1'b1 && err === 1'b0, "port disable readback");
    apb(1'b0, 12'h0fc, 32'h0);
    chk(err === 1'b1, "unmapped access");
    frame(1'b0, 1'b1);
    apb(1'b1, A_CTRL, 32'h1);
    frame(1'b0, 1'b0);
    apb(1'b1, A_SEL, 32'h0);
    apb(1'b1, A_ALO, 32'h0c0d_0e0f);
    apb(1'b1, A_AHI, 32'h0000_0a0b);
    apb(1'b1, A_PORT0 + 12'h004, 32'h2);
    frame(1'b0, 1'b1);
    apb(1'b1, A_CTRL, 32'h0);
    frame(1'b1, 1'b0);
    stop_test();
  end
endmodule : rpc_core_tb
